/* File: bsx_pkg.sv */
// bsx_pkg: register map, field positions, reset values and engine states
// of the bit-string expansion unit.
// assumes a 32-bit apb register bus and a byte-wide external memory port.
package bsx_pkg;

  localparam logic [7:0]  bsx_base_off    = 8'h00;
  localparam logic [7:0]  bsx_offset_off  = 8'h04;
  localparam logic [7:0]  bsx_count_off   = 8'h08;
  localparam logic [7:0]  bsx_tw_off      = 8'h0c;
  localparam logic [7:0]  bsx_ctrl_off    = 8'h10;
  localparam logic [7:0]  bsx_stat_off    = 8'h14;

  localparam int          bsx_ctrl_start  = 0;
  localparam int          bsx_ctrl_op     = 1;
  localparam int          bsx_stat_busy   = 0;
  localparam int          bsx_stat_long   = 1;
  localparam int          bsx_stat_done   = 2;

  localparam logic [31:0] bsx_reg_rst     = 32'h0000_0000;
  localparam logic [31:0] bsx_contig_max  = 32'h0000_0019;
  localparam logic [23:0] bsx_table_bytes = 24'h00_0400;
  localparam logic [1:0]  bsx_last_byte   = 2'h3;

  typedef enum logic [3:0] {
    bsx_st_idle = 4'h1,
    bsx_st_tbl  = 4'h2,
    bsx_st_rd   = 4'h4,
    bsx_st_wr   = 4'h8
  } bsx_state_type;

endpackage : bsx_pkg

/* File: bsx_bit_addr.sv */
// bsx_bit_addr: turns a byte base and a signed bit offset into a byte
// address and a bit position inside that byte.
// assumes a 24-bit byte address space; higher bits wrap silently.
`timescale 1ns/1ps
module bsx_bit_addr (
  input  wire logic [31:0] base,
  input  wire logic [31:0] offset,
  output logic      [23:0] byte_addr,
  output logic      [2:0]  bit_pos
);

  logic [31:0] bit_sum;

  // two's complement add lets a negative offset reach bytes below the base
  assign bit_sum   = {base[28:0], 3'h0} + offset;
  assign byte_addr = bit_sum[26:3];
  assign bit_pos   = bit_sum[2:0];

endmodule : bsx_bit_addr

/* File: bsx_unit.sv */
// bsx_unit: contiguous and perpendicular bit-string set engine with its
// operand registers on apb and a byte-wide read-modify-write memory port.
// assumes memory answers each request with a one-cycle mem_ack while
// mem_req is held, and that the lookup table is loaded before a start.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module bsx_unit
  import bsx_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [23:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack,
  output logic             busy,
  output logic             long_flag
);

  bsx_state_type st_q, st_d;
  logic [31:0] base_q, base_d, offset_q, offset_d, count_q, count_d, tw_q, tw_d;
  logic [31:0] mask_q, mask_d, prdata_q, prdata_d;
  logic [7:0]  hold_q, hold_d, wdata_q, wdata_d;
  logic [23:0] addr_q, addr_d;
  logic [1:0]  idx_q, idx_d;
  logic        op_q, op_d, busy_q, busy_d, long_q, long_d, done_q, done_d;
  logic        req_q, req_d, we_q, we_d, pready_q, pready_d, slverr_q, slverr_d;
  logic        go_long, go_short, finish, cg_next;
  logic        setup, wr_acc, mapped;
  logic [31:0] rd_mux;
  logic [23:0] tgt_byte;
  logic [2:0]  tgt_bit;
  logic [9:0]  tbl_idx;
  logic [7:0]  mask_byte, set_bits;

  bsx_bit_addr u_bit_addr (
    .base      (base_q),
    .offset    (offset_q),
    .byte_addr (tgt_byte),
    .bit_pos   (tgt_bit)
  );

  assign setup     = psel & ~penable;
  assign wr_acc    = psel & penable & pready_q & pwrite;
  // one 32-bit mask word per (count, start bit): 32 x 8 x 4 bytes = 1k
  assign tbl_idx   = {count_q[4:0], tgt_bit, idx_q};
  assign mask_byte = mask_q[{idx_q, 3'h0} +: 8];
  assign set_bits  = op_q ? (8'h01 << tgt_bit) : mask_byte;

  always_comb begin
    mapped = 1'b1;
    rd_mux = bsx_reg_rst;
    case (paddr)
      bsx_base_off:   rd_mux = base_q;
      bsx_offset_off: rd_mux = offset_q;
      bsx_count_off:  rd_mux = count_q;
      bsx_tw_off:     rd_mux = tw_q;
      bsx_ctrl_off:   rd_mux = {30'h0, op_q, 1'b0};
      bsx_stat_off:   rd_mux = {29'h0, done_q, long_q, busy_q};
      default:        mapped = 1'b0;
    endcase
  end

  always_comb begin
    st_d     = st_q;
    base_d   = base_q;
    offset_d = offset_q;
    count_d  = count_q;
    tw_d     = tw_q;
    mask_d   = mask_q;
    hold_d   = hold_q;
    wdata_d  = wdata_q;
    addr_d   = addr_q;
    idx_d    = idx_q;
    op_d     = op_q;
    busy_d   = busy_q;
    long_d   = long_q;
    done_d   = done_q;
    req_d    = req_q;
    we_d     = we_q;
    go_long  = 1'b0;
    go_short = 1'b0;
    finish   = 1'b0;
    cg_next  = 1'b0;
    // zero-wait slave: read data is latched in the setup cycle
    pready_d = setup;
    slverr_d = setup & ~mapped;
    prdata_d = setup ? rd_mux : prdata_q;

    // operand writes during a run are dropped so the run stays coherent
    if (wr_acc && !busy_q) begin
      case (paddr)
        bsx_base_off:   base_d   = pwdata;
        bsx_offset_off: offset_d = pwdata;
        bsx_count_off:  count_d  = pwdata;
        bsx_tw_off:     tw_d     = pwdata;
        bsx_ctrl_off: begin
          if (pwdata[bsx_ctrl_start]) begin
            op_d   = pwdata[bsx_ctrl_op];
            done_d = 1'b0;
            idx_d  = 2'h0;
            if (!pwdata[bsx_ctrl_op]) begin
              if (count_q > bsx_contig_max) begin
                go_long = 1'b1;
                long_d  = 1'b1;
                done_d  = 1'b1;
              end else begin
                go_short = 1'b1;
                long_d   = 1'b0;
                if (count_q == bsx_reg_rst) begin
                  done_d = 1'b1;
                end else begin
                  busy_d = 1'b1;
                  st_d   = bsx_st_tbl;
                end
              end
            end else if (count_q == bsx_reg_rst) begin
              done_d = 1'b1;
            end else begin
              busy_d = 1'b1;
              st_d   = bsx_st_rd;
            end
          end
        end
        default: ;
      endcase
    end

    case (st_q)
      bsx_st_idle: ;
      bsx_st_tbl: begin
        if (!req_q) begin
          req_d  = 1'b1;
          we_d   = 1'b0;
          addr_d = tw_q[23:0] + {14'h0, tbl_idx};
        end else if (mem_ack) begin
          req_d = 1'b0;
          mask_d[{idx_q, 3'h0} +: 8] = mem_rdata;
          if (idx_q == bsx_last_byte) begin
            idx_d = 2'h0;
            st_d  = bsx_st_rd;
          end else begin
            idx_d = idx_q + 2'h1;
          end
        end
      end
      bsx_st_rd: begin
        // bytes the pattern leaves empty need no memory cycle at all
        if (!op_q && mask_byte == 8'h00) begin
          cg_next = 1'b1;
        end else if (!req_q) begin
          req_d  = 1'b1;
          we_d   = 1'b0;
          addr_d = tgt_byte + (op_q ? 24'h0 : {22'h0, idx_q});
        end else if (mem_ack) begin
          req_d  = 1'b0;
          hold_d = mem_rdata;
          st_d   = bsx_st_wr;
        end
      end
      bsx_st_wr: begin
        if (!req_q) begin
          req_d   = 1'b1;
          we_d    = 1'b1;
          wdata_d = hold_q | set_bits;
        end else if (mem_ack) begin
          req_d = 1'b0;
          we_d  = 1'b0;
          if (!op_q) begin
            cg_next = 1'b1;
          end else begin
            count_d = count_q - 32'h0000_0001;
            if (count_q == 32'h0000_0001) begin
              finish = 1'b1;
            end else begin
              // signed add: +1/-1 walks the scan line, larger warps cross lines
              offset_d = offset_q + tw_q;
              st_d     = bsx_st_rd;
            end
          end
        end
      end
      default: st_d = bsx_st_idle;
    endcase

    if (cg_next) begin
      if (idx_q == bsx_last_byte) begin
        finish = 1'b1;
      end else begin
        idx_d = idx_q + 2'h1;
        st_d  = bsx_st_rd;
      end
    end
    if (finish) begin
      st_d   = bsx_st_idle;
      busy_d = 1'b0;
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= bsx_st_idle;
      base_q   <= bsx_reg_rst;
      offset_q <= bsx_reg_rst;
      count_q  <= bsx_reg_rst;
      tw_q     <= bsx_reg_rst;
      mask_q   <= bsx_reg_rst;
      prdata_q <= bsx_reg_rst;
      hold_q   <= 8'h00;
      wdata_q  <= 8'h00;
      addr_q   <= 24'h00_0000;
      idx_q    <= 2'h0;
      op_q     <= 1'b0;
      busy_q   <= 1'b0;
      long_q   <= 1'b0;
      done_q   <= 1'b0;
      req_q    <= 1'b0;
      we_q     <= 1'b0;
      pready_q <= 1'b0;
      slverr_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      base_q   <= base_d;
      offset_q <= offset_d;
      count_q  <= count_d;
      tw_q     <= tw_d;
      mask_q   <= mask_d;
      prdata_q <= prdata_d;
      hold_q   <= hold_d;
      wdata_q  <= wdata_d;
      addr_q   <= addr_d;
      idx_q    <= idx_d;
      op_q     <= op_d;
      busy_q   <= busy_d;
      long_q   <= long_d;
      done_q   <= done_d;
      req_q    <= req_d;
      we_q     <= we_d;
      pready_q <= pready_d;
      slverr_q <= slverr_d;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = slverr_q;
  assign mem_req   = req_q;
  assign mem_we    = we_q;
  assign mem_addr  = addr_q;
  assign mem_wdata = wdata_q;
  assign busy      = busy_q;
  assign long_flag = long_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_long_no_access: assert property (
    go_long |=> (long_q && !busy_q && !req_q) ##1 (!req_q)[*2])
    else $error("long contiguous string started memory activity");
  chk_short_clears: assert property (
    go_short |=> !long_q)
    else $error("short contiguous string left long flag set");
  chk_contig_keeps: assert property (
    busy_q && !op_q |=> $stable(base_q) && $stable(offset_q)
                        && $stable(count_q) && $stable(tw_q))
    else $error("contiguous set changed an operand register");
  chk_perp_end: assert property (
    $fell(busy_q) && op_q |-> count_q == 32'h0 && $stable(base_q) && $stable(tw_q))
    else $error("perpendicular set ended with bad registers");
  chk_warp_step: assert property (
    st_q == bsx_st_wr && op_q && req_q && mem_ack && count_q != 32'h1
    |=> offset_q == $past(offset_q) + tw_q && count_q == $past(count_q) - 32'h1)
    else $error("perpendicular step did not add warp");
  chk_rmw_keep: assert property (
    $rose(req_q) && we_q |-> (wdata_q & hold_q) == hold_q
                             && (wdata_q & ~hold_q & ~set_bits) == 8'h00)
    else $error("write disturbed bits outside the target");
  chk_table_window: assert property (
    req_q && st_q == bsx_st_tbl |-> (addr_q - tw_q[23:0]) < bsx_table_bytes)
    else $error("table fetch outside the lookup table");
  chk_perp_addr: assert property (
    $rose(req_q) && !we_q && op_q |-> addr_q == tgt_byte)
    else $error("perpendicular read at wrong byte");
  chk_bus_ready: assert property (
    setup |=> pready_q ##1 !pready_q)
    else $error("apb ready not a single access cycle");

endmodule : bsx_unit

/* File: bsx_mem_model.sv */
// bsx_mem_model: byte-wide external memory for frame buffer and lookup table.
// assumes one request at a time; the bench loads mem before any start.
`timescale 1ns/1ps
module bsx_mem_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [3:0]  delay,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  output logic             mem_ack
);
  logic [7:0] mem [0:4095];
  logic [3:0] wait_q;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack   <= 1'b0;
      wait_q    <= 4'h0;
      mem_rdata <= 8'h5a;
    end else begin
      mem_ack   <= 1'b0;
      // read data only counts with ack, so it churns in between
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_q < delay) begin
          wait_q <= wait_q + 4'h1;
        end else begin
          wait_q  <= 4'h0;
          mem_ack <= 1'b1;
          if (mem_we) mem[mem_addr[11:0]] <= mem_wdata;
          else mem_rdata <= mem[mem_addr[11:0]];
        end
      end
    end
  end
endmodule : bsx_mem_model

/* File: bsx_unit_tb.sv */
// bsx_unit_tb: drives the unit over apb against the memory model and
// checks registers, flags and memory against a shadow copy.
// assumes the unit answers apb with pready and the memory model answers with mem_ack.
`timescale 1ns/1ps
module bsx_unit_tb
  import bsx_pkg::*;
;
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        mem_req, mem_we, mem_ack, busy, long_flag, lf;
  logic [7:0]  paddr, mem_rdata, mem_wdata;
  logic [31:0] pwdata, prdata;
  logic [23:0] mem_addr;
  logic [3:0]  mem_delay;
  logic [7:0]  shadow [0:4095];
  int          err_count, n_tests;
  int          cycles = 0;

  bsx_unit u_dut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .busy, .long_flag);
  bsx_mem_model u_mem (.clock, .rst_b, .delay(mem_delay), .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack);

  task automatic complete_run();
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // request stands until pready is seen at a rising edge; the ceiling ends a hang
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, 32'h0);
  endtask : rd

  // one operation on base 0x100 (bit 2048), then registers, flag and frame
  task automatic run(input logic op, input int off, input int cnt, input int tw);
    logic [31:0] q;
    logic        e;
    int          n, b, fin;
    fin = off;
    wr(bsx_base_off, 32'h100);
    wr(bsx_offset_off, 32'(off));
    wr(bsx_count_off, 32'(cnt));
    wr(bsx_tw_off, 32'(tw));
    wr(bsx_ctrl_off, {30'h0, op, 1'b1});
    @(posedge clock);
    chk({31'h0, busy}, {31'h0, cnt != 0 && (op || cnt <= 25)});
    for (n = 0; n < cnt; n++) begin
      if (op) fin = off + n * tw;
      b = op ? fin + 2048 : off + n + 2048;
      if (op || cnt <= 25) shadow[b >> 3][b & 7] = 1'b1;
    end
    if (!op) lf = (cnt > 25);
    q = 32'h0;
    // a run that never ends is caught by the cycle ceiling
    while (q[bsx_stat_done] !== 1'b1) apb(1'b0, bsx_stat_off, 32'h0, q, e);
    chk(q, {29'h0, 1'b1, lf, 1'b0});
    chk({31'h0, long_flag}, {31'h0, lf});
    chk({31'h0, busy}, 32'h0);
    rd(bsx_base_off, 32'h100);
    rd(bsx_offset_off, 32'(fin));
    rd(bsx_count_off, op ? 32'h0 : 32'(cnt));
    rd(bsx_tw_off, 32'(tw));
    for (n = 128; n < 512; n++) chk({24'h0, u_mem.mem[n]}, {24'h0, shadow[n]});
  endtask : run

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    logic [63:0] m;
    logic [31:0] q;
    logic        e;
    {rst_b, psel, penable, pwrite, paddr, pwdata, mem_delay, lf} = '0;
    err_count = 0;
    n_tests   = 0;
    for (int i = 0; i < 4096; i++) begin
      shadow[i]    = 8'(i * 37);
      u_mem.mem[i] = shadow[i];
    end
    for (int c = 0; c < 32; c++)
      for (int s = 0; s < 8; s++)
        for (int k = 0; k < 4; k++) begin
          m = ((64'h1 << c) - 64'h1) << s;
          u_mem.mem[2048 + c * 32 + s * 4 + k] = m[8 * k +: 8];
        end
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    for (int a = 0; a < 24; a += 4) rd(8'(a), 32'h0);
    apb(1'b0, 8'h18, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    run(1'b0, 5, 25, 2048);
    run(1'b0, 29, 26, 2048);
    run(1'b0, -3, 7, 2048);
    run(1'b0, 40, 0, 2048);
    mem_delay <= 4'h3;
    run(1'b0, 60, 13, 2048);
    run(1'b1, 3, 5, 80);
    mem_delay <= 4'h0;
    run(1'b1, -9, 5, -80);
    run(1'b1, 100, 6, 1);
    run(1'b1, 120, 6, -1);
    run(1'b1, 7, 0, 8);
    complete_run();
  end
endmodule : bsx_unit_tb
